// ===== bench/ddsw_link_chk.sv
// Checker of framing and timing on the serial link between the two ends.
`timescale 1ns/1ps
module ddsw_link_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Link.
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din
);
  logic [4:0] fall_q;
  logic [3:0] gap_q;
  logic       sclk_q;
  wire        fall_w = sclk_q & ~sclk;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  // Counts falls in a frame and cycles since a word completed.
  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_q <= 1'b0;
      fall_q <= 5'h00;
      gap_q  <= 4'hf;
    end else begin
      sclk_q <= sclk;
      fall_q <= sync_n ? 5'h00 : fall_q + {4'h0, fall_w};
      gap_q  <= (fall_w && fall_q == 5'h17) ? 4'h0 : gap_q + {3'h0, gap_q != 4'hf};
    end
  end
  // The clock rests low outside frames and a frame opens with it high.
  a_idle_clock_low: assert property (sync_n |-> !sclk) else $error("Clock high outside frame.");
  a_start_clock_high: assert property ($fell(sync_n) |-> sclk) else $error("Frame opened low.");
  // Data is steady across the capturing edge.
  a_data_steady_fall: assert property ($fell(sclk) |-> $stable(din)) else $error("Data moved at fall.");
  // Half periods stay four cycles, well under the rate limit.
  a_high_half_period: assert property ($rose(sclk) |-> sclk[*4]) else $error("High phase short.");
  a_low_half_period: assert property ($fell(sclk) |-> !sclk[*4]) else $error("Low phase short.");
  // Exactly 24 falls per frame, and a gap before the next one.
  a_falls_bounded: assert property (fall_q <= 5'h18) else $error("Too many falls in frame.");
  a_frame_whole: assert property ($rose(sync_n) |-> fall_q == 5'h18) else $error("Frame not whole.");
  a_reframe_gap: assert property ($fell(sync_n) |-> gap_q >= 4'h9) else $error("Reframe too soon.");
endmodule

// ===== bench/tb_top.sv
// Testbench for both link ends, plus a driver that breaks framing on a second link.
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        word_valid = 1'b0;
  logic [23:0] word_data = 24'h000000;
  logic        word_ready, busy, cmd_valid, la, lb, bs, p1, p0, rsv, abt, v2, abt2;
  logic [15:0] data, data2, d2_q;
  logic        sclk_q = 1'b0;
  logic        saw_full = 1'b0;
  logic [23:0] mon_q = 24'h000000;
  logic [23:0] w;
  int          fail_count = 0;
  int          checked = 0;
  int          n_cmd = 0;
  int          n_v2 = 0;
  int          n_abt2 = 0;
  logic [23:0] words [10] = '{24'h10a5a5, 24'h21ffff, 24'h340001, 24'h378000, 24'h1b1234,
                              24'h2f0f0f, 24'h800000, 24'h40fffe, 24'h3a5678, 24'h00c3c3};
  ddsw_if link_if ();
  ddsw_if bad_if ();
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////
  ddsw_host ddsw_host_inst (.clk(clk), .srst(srst), .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data), .busy(busy), .link(link_if));
  ddsw_device ddsw_device_inst (.clk(clk), .srst(srst), .link(link_if), .cmd_valid(cmd_valid),
    .load_channel_a(la), .load_channel_b(lb), .buffer_select_b(bs), .powerdown_mode_bit1(p1),
    .powerdown_mode_bit0(p0), .cmd_data(data), .reserved_error(rsv), .abort_seen(abt));
  ddsw_device ddsw_device_inst_2 (.clk(clk), .srst(srst), .link(bad_if), .cmd_valid(v2),
    .load_channel_a(), .load_channel_b(), .buffer_select_b(), .powerdown_mode_bit1(),
    .powerdown_mode_bit0(), .cmd_data(data2), .reserved_error(), .abort_seen(abt2));
  ddsw_link_chk ddsw_link_chk_inst (.clk(clk), .srst(srst), .sync_n(link_if.sync_n),
    .sclk(link_if.sclk), .din(link_if.din));
  // Compares one value and reports a mismatch.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Waits, bounded, until a counter reaches a value.
  task automatic wait_cnt(ref int cnt, input int want);
    for (int i = 0; i < 5000 && cnt < want; i++) begin
      @(posedge clk);
    end
    if (cnt < want) begin
      fail_count++;
      complete_run();
    end
  endtask
  // Offers one word and holds it until taken, noting any refusal.
  task automatic push(input logic [23:0] wd);
    word_valid <= 1'b1;
    word_data <= wd;
    for (int i = 0; i < 1000; i++) begin
      @(posedge clk);
      if (word_ready === 1'b1) begin
        return;
      end
      saw_full <= 1'b1;
    end
    fail_count++;
    complete_run();
  endtask
  // Sends n bits msb first on the second link with a free 125 ns clock, then closes the frame.
  task automatic send(input logic [31:0] v, input int n);
    @(posedge clk);
    #3 bad_if.sync_n = 1'b0;
    #62.5;
    for (int i = 31; i > 31 - n; i--) begin
      bad_if.din = v[i];
      bad_if.sclk = 1'b1;
      #62.5 bad_if.sclk = 1'b0;
      #30 bad_if.din = ~v[i];
      #32.5;
    end
    bad_if.sync_n = 1'b1;
    #200;
  endtask
  // Collects wire bits and decoded words and compares them with the sent list.
  always @(posedge clk) begin
    sclk_q <= link_if.sclk;
    if (sclk_q && !link_if.sclk) begin
      mon_q <= {mon_q[22:0], link_if.din};
    end
    if (cmd_valid === 1'b1 && n_cmd < 10) begin
      w = words[n_cmd];
      check({8'h00, mon_q}, {8'h00, w});
      check({10'h0, rsv, lb, la, bs, p1, p0, data}, {10'h0, w[23] | w[22], w[21:20], w[18:16], w[15:0]});
      n_cmd++;
    end
    if (!srst && abt !== 1'b0) begin
      check({31'h0, abt}, 32'h0);
    end
    if (v2 === 1'b1) begin
      n_v2++;
      d2_q <= data2;
    end
    if (abt2 === 1'b1) begin
      n_abt2++;
    end
  end
  // Main sequence.
  initial begin
    bad_if.sync_n = 1'b1;
    bad_if.sclk = 1'b0;
    bad_if.din = 1'b0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    foreach (words[k]) begin
      push(words[k]);
    end
    word_valid <= 1'b0;
    check({31'h0, saw_full}, 32'h1);
    check({31'h0, busy}, 32'h1);
    wait_cnt(n_cmd, 10);
    repeat (30) @(posedge clk);
    check({31'h0, busy}, 32'h0);
    send(32'h5a5a5a5a, 10);
    check(n_abt2, 1);
    check(n_v2, 0);
    send(32'h10beefc0, 26);
    check(n_v2, 1);
    check({16'h0, d2_q}, 32'h0000beef);
    check(n_abt2, 1);
    complete_run();
  end
endmodule

// ===== src/ddsw_device.sv
// Device end: samples the serial link and decodes each completed 24-bit word.
`timescale 1ns/1ps
module ddsw_device import ddsw_pkg::*; (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 srst,
  // Link.
  ddsw_if.device                    link,
  // Decoded command.
  output logic                      cmd_valid,
  output logic                      load_channel_a,
  output logic                      load_channel_b,
  output logic                      buffer_select_b,
  output logic                      powerdown_mode_bit1,
  output logic                      powerdown_mode_bit0,
  output logic [DATA_BITS-1:0]      cmd_data,
  output logic                      reserved_error,
  output logic                      abort_seen
);
  ///////////////////////////////////////////////////////////////////////////
  logic [2:0]           sync_s_q;
  logic [2:0]           sclk_s_q;
  logic [1:0]           din_s_q;
  logic [WORD_BITS-1:0] sh_q;
  logic [CNT_BITS-1:0]  cnt_q;
  logic                 locked_q;
  logic                 cmd_valid_q;
  logic [CTRL_BITS-1:0] ctrl_q;
  logic [DATA_BITS-1:0] data_q;
  logic                 abort_q;

  // Two-stage synchronisers; the third stage only remembers the past level.
  always_ff @(posedge clk) begin
    if (srst) begin
      sync_s_q <= 3'h7;
      sclk_s_q <= 3'h0;
      din_s_q  <= 2'h0;
    end else begin
      sync_s_q <= {sync_s_q[1:0], link.sync_n};
      sclk_s_q <= {sclk_s_q[1:0], link.sclk};
      din_s_q  <= {din_s_q[0], link.din};
    end
  end

  // Edge decodes from the settled stages.
  wire frame_on  = !sync_s_q[1];
  wire sync_rise = sync_s_q[1] && !sync_s_q[2];
  wire sclk_fall = !sclk_s_q[1] && sclk_s_q[2];
  wire take_bit  = frame_on && sclk_fall && !locked_q;
  wire last_bit  = (cnt_q == LAST_BIT);
  wire [WORD_BITS-1:0] word_next = {sh_q[WORD_BITS-2:0], din_s_q[1]};

  // Shift register, bit counter and lock.
  always_ff @(posedge clk) begin
    if (srst) begin
      sh_q     <= WORD_RST;
      cnt_q    <= COUNT_RST;
      locked_q <= 1'b0;
    end else if (!frame_on) begin
      // Select high discards any partial word and rearms the port.
      sh_q     <= WORD_RST;
      cnt_q    <= COUNT_RST;
      locked_q <= 1'b0;
    end else if (take_bit) begin
      sh_q  <= word_next;
      cnt_q <= cnt_q + 5'h01;
      if (last_bit) locked_q <= 1'b1;
    end
  end

  // Command capture on the final edge, without waiting for select to rise.
  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_valid_q <= 1'b0;
      ctrl_q      <= 8'h00;
      data_q      <= 16'h0000;
      abort_q     <= 1'b0;
    end else begin
      cmd_valid_q <= take_bit && last_bit;
      abort_q     <= sync_rise && !locked_q && (cnt_q != COUNT_RST);
      if (take_bit && last_bit) begin
        ctrl_q <= word_next[WORD_BITS-1:DATA_BITS];
        data_q <= word_next[DATA_BITS-1:0];
      end
    end
  end

  // Control byte fields.
  assign cmd_valid           = cmd_valid_q;
  assign load_channel_a      = ctrl_q[LOAD_A_POS - DATA_BITS];
  assign load_channel_b      = ctrl_q[LOAD_B_POS - DATA_BITS];
  assign buffer_select_b     = ctrl_q[BUF_SEL_POS - DATA_BITS];
  assign powerdown_mode_bit1 = ctrl_q[PD1_POS - DATA_BITS];
  assign powerdown_mode_bit0 = ctrl_q[PD0_POS - DATA_BITS];
  assign reserved_error      = ctrl_q[RSVD_HI_POS - DATA_BITS] | ctrl_q[RSVD_LO_POS - DATA_BITS];
  assign cmd_data            = data_q;
  assign abort_seen          = abort_q;
endmodule

// ===== src/ddsw_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module ddsw_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             srst,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // Full when pointers differ only in the wrap bit.
  assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data  = mem[rd_q[AW-1:0]];

  // Pointer update.
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  // Storage write.
  always_ff @(posedge clk) begin
    if (push) mem[wr_q[AW-1:0]] <= in_data;
  end
endmodule

// ===== src/ddsw_host.sv
// Host end: takes 24-bit words from a FIFO and sends them over the serial link.
`timescale 1ns/1ps
module ddsw_host import ddsw_pkg::*; #(
  parameter int unsigned HALF_CYC = HALF_PERIOD_CYC,
  parameter int unsigned GAP_CYC  = REFRAME_GAP_CYC
) (
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 srst,
  // User word stream.
  input  wire logic                 word_valid,
  output logic                      word_ready,
  input  wire logic [WORD_BITS-1:0] word_data,
  // Status.
  output logic                      busy,
  // Link.
  ddsw_if.host                      link
);
  ///////////////////////////////////////////////////////////////////////////
  logic                 f_valid;
  logic                 f_ready;
  logic [WORD_BITS-1:0] f_data;
  ddsw_host_state_t     st_q;
  ddsw_host_state_t     st_d;
  logic [WORD_BITS-1:0] sh_q;
  logic [CNT_BITS-1:0]  bit_q;
  logic [7:0]           div_q;
  logic                 sclk_q;
  logic                 sync_n_q;
  logic                 busy_q;

  // The FIFO stalls the user when the link cannot keep up.
  ddsw_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (word_valid),
    .in_ready  (word_ready),
    .in_data   (word_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // Divider tick and edge decodes.
  wire tick      = (div_q == 8'(HALF_CYC - 1));
  wire fall_tick = tick && sclk_q;
  wire rise_tick = tick && !sclk_q;
  wire last_bit  = (bit_q == LAST_BIT);
  assign f_ready = (st_q == DDSW_IDLE);

  // Next state.
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      DDSW_IDLE:  if (f_valid) st_d = DDSW_SHIFT;
      DDSW_SHIFT: if (fall_tick && last_bit) st_d = DDSW_END;
      DDSW_END:   if (tick) st_d = DDSW_GAP;
      DDSW_GAP:   if (div_q == 8'(GAP_CYC)) st_d = DDSW_IDLE;
    endcase
  end

  // Frame, clock and data sequencing.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q     <= DDSW_IDLE;
      sh_q     <= WORD_RST;
      bit_q    <= COUNT_RST;
      div_q    <= 8'h00;
      sclk_q   <= 1'b0;
      sync_n_q <= 1'b1;
      busy_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      busy_q <= (st_d != DDSW_IDLE);
      unique case (st_q)
        DDSW_IDLE: begin
          // The clock rests low between frames and rises in the same cycle that select falls.
          div_q <= 8'h00;
          if (f_valid) begin
            sh_q     <= f_data;
            sclk_q   <= 1'b1;
            sync_n_q <= 1'b0;
            bit_q    <= COUNT_RST;
          end
        end
        DDSW_SHIFT: begin
          div_q <= tick ? 8'h00 : div_q + 8'h01;
          if (tick) sclk_q <= !sclk_q;
          if (fall_tick) bit_q <= bit_q + 5'h01;
          // New bit set up on the rising edge, msb first.
          if (rise_tick && bit_q != COUNT_RST) sh_q <= {sh_q[WORD_BITS-2:0], 1'b0};
        end
        DDSW_END: begin
          div_q <= tick ? 8'h00 : div_q + 8'h01;
          if (tick) sync_n_q <= 1'b1;
        end
        DDSW_GAP: begin
          // Gap counted from the rise of select covers the 100 ns minimum.
          div_q <= div_q + 8'h01;
        end
      endcase
    end
  end

  // Link pins come from flip-flops; the rate stays at 12.5 MHz, below both supply limits.
  assign link.sclk   = sclk_q;
  assign link.sync_n = sync_n_q;
  assign link.din    = sh_q[WORD_BITS-1];
  assign busy        = busy_q;
endmodule

// ===== src/ddsw_if.sv
// Interface joining the host and device ends of the three-wire serial link.
`timescale 1ns/1ps
interface ddsw_if;
  logic sync_n;
  logic sclk;
  logic din;

  modport host (output sync_n, output sclk, output din);
  modport device (input sync_n, input sclk, input din);
endinterface

// ===== src/ddsw_pkg.sv
// Package with shared constants and types for the dual converter serial write port.
package ddsw_pkg;

  // Word layout.
  localparam int unsigned WORD_BITS     = 24;
  localparam int unsigned DATA_BITS     = 16;
  localparam int unsigned CTRL_BITS     = 8;
  localparam int unsigned CNT_BITS      = 5;
  localparam int unsigned RSVD_HI_POS   = 23;
  localparam int unsigned RSVD_LO_POS   = 22;
  localparam int unsigned LOAD_B_POS    = 21;
  localparam int unsigned LOAD_A_POS    = 20;
  localparam int unsigned DONT_CARE_POS = 19;
  localparam int unsigned BUF_SEL_POS   = 18;
  localparam int unsigned PD1_POS       = 17;
  localparam int unsigned PD0_POS       = 16;

  // Reset values.
  localparam logic [WORD_BITS-1:0] WORD_RST  = 24'h000000;
  localparam logic [CNT_BITS-1:0]  COUNT_RST = 5'h00;
  localparam logic [CNT_BITS-1:0]  LAST_BIT  = 5'h17;

  // Timing, system clock 100 MHz.
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned REFRAME_GAP_NS = 100;
  localparam int unsigned REFRAME_GAP_CYC =
    (REFRAME_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SCLK_MAX_HI_SUPPLY_MHZ = 30;
  localparam int unsigned SCLK_MAX_LO_SUPPLY_MHZ = 20;
  // Host divider: half period in system cycles, 40 ns gives 12.5 MHz.
  localparam int unsigned HALF_PERIOD_CYC = 4;
  localparam int unsigned FIFO_DEPTH      = 8;

  // Host sender states.
  typedef enum logic [3:0] {
    DDSW_IDLE  = 4'b0001,
    DDSW_SHIFT = 4'b0010,
    DDSW_END   = 4'b0100,
    DDSW_GAP   = 4'b1000
  } ddsw_host_state_t;

endpackage
